// File: logic/plrc_ms_tick.sv
`timescale 1ns/1ps

module plrc_ms_tick #(
  parameter int CYC_PER_MS = 40000
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);

  localparam int CW = $clog2(CYC_PER_MS + 1);

  logic [CW-1:0] div_reg;

  // ----------------------------------------------------------------------------
  // Free-running divider giving one enable pulse per millisecond.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
      tick_o  <= 1'b0;
    end else if (div_reg == CW'(CYC_PER_MS - 1)) begin
      div_reg <= '0;
      tick_o  <= 1'b1;
    end else begin
      div_reg <= div_reg + CW'(1);
      tick_o  <= 1'b0;
    end
  end

endmodule

// File: logic/plrc_pkg.sv
package plrc_pkg;

  typedef enum logic [1:0] {
    PLRC_POL_OFF  = 2'h0,
    PLRC_POL_ON   = 2'h1,
    PLRC_POL_PREV = 2'h2,
    PLRC_POL_USER = 2'h3
  } plrc_policy_e;

  typedef enum logic [1:0] {
    PLRC_ST_OFF  = 2'h0,
    PLRC_ST_ON   = 2'h1,
    PLRC_ST_DOWN = 2'h3
  } plrc_state_e;

endpackage

// File: logic/plrc_regs.svh
`ifndef PLRC_REGS_SVH
`define PLRC_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define PLRC_ADDR_W          8
`define PLRC_DATA_W          8
`define PLRC_ADDR_POLICY     8'hE4
`define PLRC_ADDR_LAST       8'hE6
`define PLRC_ADDR_STATUS     8'hF0

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PLRC_POLICY_LSB      5
`define PLRC_POLICY_MSB      6
`define PLRC_LAST_BIT        4
`define PLRC_ST_SUPPLY_BIT   0
`define PLRC_ST_GATE_BIT     1
`define PLRC_ST_STATE_LSB    2
`define PLRC_ST_STATE_MSB    3
`define PLRC_ST_SLEEP_BIT    4
`define PLRC_ST_RAIL_BIT     5
`define PLRC_ST_AC_BIT       6
`define PLRC_POLICY_RST      2'h0
`define PLRC_LAST_RST        1'b1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PLRC_CLK_PERIOD_NS   25
`define PLRC_NS_PER_MS       1000000
`define PLRC_CYC_PER_MS      (`PLRC_NS_PER_MS / `PLRC_CLK_PERIOD_NS)
`define PLRC_SWITCH_MAX_NS   80
`define PLRC_OFF_MIN_MS      28
`define PLRC_OFF_MAX_MS      39
`define PLRC_GATE_MIN_MS     90
`define PLRC_GATE_MAX_MS     142
`define PLRC_OFF_TICKS       (`PLRC_OFF_MIN_MS + 1)
`define PLRC_GATE_TICKS      (`PLRC_GATE_MIN_MS + 1)

`endif

// File: logic/plrc_sync.sv
`timescale 1ns/1ps

module plrc_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

// File: logic/plrc_top.sv
// How it works
// - Policy 00: stay off after AC returns.
// - Policy 01: always switch on after AC.
// - Policy 10: restore automatically captured previous state.
// - Policy 11: use firmware-written last-state flag.
// - Last-state flag bit 4: 0 on, 1 off.
// - Policy field bits 6:5, read/write, battery-held.
// - Rail drop with sleep high records on.
// - Rail drop with sleep low records off.
// - Supply off 28 to 39 ms after sleep.
// - Gate released 90 to 142 ms after supply.
// - Gate asserted within 80 ns of sleep.
// - Supply asserted within 80 ns of wake.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "plrc_regs.svh"

module plrc_top
  import plrc_pkg::*;
#(
  parameter int CYC_PER_MS = `PLRC_CYC_PER_MS,
  parameter int OFF_TICKS  = `PLRC_OFF_TICKS,
  parameter int GATE_TICKS = `PLRC_GATE_TICKS
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [`PLRC_ADDR_W-1:0] addr_i,
  input  wire logic [`PLRC_DATA_W-1:0] wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [`PLRC_DATA_W-1:0] rdata_o,
  input  wire logic                    sleep_state_n_i,
  input  wire logic                    main_rail_low_i,
  input  wire logic                    ac_good_i,
  output logic                         supply_on_n_o,
  output logic                         standby_rail_gate_n_o
);

  localparam int TW = 8;

  // Synchroniser and edge-detector reset levels match the idle pin levels
  // {ac_good, rail_low, sleep_n}, so leaving reset never fakes a wake or a
  // rail drop that would power the system up or overwrite the last-state flag.
  localparam logic [2:0] PIN_RST = 3'h3;

  // ----------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------------
  logic [2:0]   pins_s;
  logic         sleep_n_s;
  logic         rail_low_s;
  logic         ac_good_s;
  logic         sleep_n_d_reg;
  logic         rail_low_d_reg;
  logic         ac_good_d_reg;
  logic         wake_edge;
  logic         rail_drop;
  logic         ac_rise;
  logic         ms_tick;

  plrc_sync #(
    .WIDTH   (3),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({ac_good_i, main_rail_low_i, sleep_state_n_i}),
    .sync_o  (pins_s)
  );

  // ----------------------------------------------------------------------------
  // Millisecond enable
  // ----------------------------------------------------------------------------

  plrc_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_o  (ms_tick)
  );

  assign sleep_n_s  = pins_s[0];
  assign rail_low_s = pins_s[1];
  assign ac_good_s  = pins_s[2];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_n_d_reg  <= PIN_RST[0];
      rail_low_d_reg <= PIN_RST[1];
      ac_good_d_reg  <= PIN_RST[2];
    end else begin
      sleep_n_d_reg  <= sleep_n_s;
      rail_low_d_reg <= rail_low_s;
      ac_good_d_reg  <= ac_good_s;
    end
  end

  assign wake_edge = sleep_n_s & ~sleep_n_d_reg;
  assign rail_drop = rail_low_s & ~rail_low_d_reg;
  assign ac_rise   = ac_good_s & ~ac_good_d_reg;

  // ----------------------------------------------------------------------------
  // Battery-held policy field and last-state flag
  // ----------------------------------------------------------------------------
  plrc_policy_e policy_reg;
  logic         last_off_reg;
  logic         wr_policy;
  logic         wr_last;

  // Writes to any other address, the status word included, are ignored.
  assign wr_policy = wr_i && (addr_i == `PLRC_ADDR_POLICY);
  assign wr_last   = wr_i && (addr_i == `PLRC_ADDR_LAST);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      policy_reg <= plrc_policy_e'(`PLRC_POLICY_RST);
    end else if (wr_policy) begin
      policy_reg <= plrc_policy_e'(wdata_i[`PLRC_POLICY_MSB:`PLRC_POLICY_LSB]);
    end
  end

  // Automatic capture only runs outside user mode, so a firmware preset is
  // never overwritten; a capture in the same cycle as a write wins.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_off_reg <= `PLRC_LAST_RST;
    end else if (rail_drop && policy_reg != PLRC_POL_USER) begin
      last_off_reg <= ~sleep_n_s;
    end else if (wr_last) begin
      last_off_reg <= wdata_i[`PLRC_LAST_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // Resume decision on AC recovery
  // ----------------------------------------------------------------------------
  logic resume_on;

  // Policies 10 and 11 both read the one flag; they differ only in whether
  // a rail drop may update it.
  always_comb begin
    unique case (policy_reg)
      PLRC_POL_OFF:  resume_on = 1'b0;
      PLRC_POL_ON:   resume_on = 1'b1;
      PLRC_POL_PREV: resume_on = ~last_off_reg;
      PLRC_POL_USER: resume_on = ~last_off_reg;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Supply sequencer
  // ----------------------------------------------------------------------------
  plrc_state_e state_reg;
  logic [TW-1:0] off_cnt_reg;

  // Besides an AC return with resume_on set, only a rising sleep edge wakes the system from off, so a sleep input that
  // is merely high after AC recovery under an off policy keeps it off.
  // Losing AC drops the supply at once, whatever the state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= PLRC_ST_OFF;
      supply_on_n_o <= 1'b1;
    end else if (!ac_good_s) begin
      state_reg     <= PLRC_ST_OFF;
      supply_on_n_o <= 1'b1;
    end else begin
      unique case (state_reg)
        PLRC_ST_OFF: begin
          if ((ac_rise && resume_on) || (!ac_rise && wake_edge)) begin
            state_reg     <= PLRC_ST_ON;
            supply_on_n_o <= 1'b0;
          end
        end
        PLRC_ST_ON: begin
          if (!sleep_n_s) begin
            state_reg <= PLRC_ST_DOWN;
          end
        end
        PLRC_ST_DOWN: begin
          if (sleep_n_s) begin
            state_reg     <= PLRC_ST_ON;
            supply_on_n_o <= 1'b0;
          end else if (ms_tick && off_cnt_reg == TW'(OFF_TICKS - 1)) begin
            state_reg     <= PLRC_ST_OFF;
            supply_on_n_o <= 1'b1;
          end
        end
        default: begin
          state_reg     <= PLRC_ST_OFF;
          supply_on_n_o <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Power-down timer
  // ----------------------------------------------------------------------------
  // Counts whole millisecond ticks; the free-running tick phase makes the
  // delay land between OFF_TICKS-1 and OFF_TICKS milliseconds.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_cnt_reg <= '0;
    end else if (state_reg != PLRC_ST_DOWN) begin
      off_cnt_reg <= '0;
    end else if (ms_tick) begin
      off_cnt_reg <= off_cnt_reg + TW'(1);
    end
  end

  // ----------------------------------------------------------------------------
  // Standby-rail gate
  // ----------------------------------------------------------------------------
  logic [TW-1:0] gate_cnt_reg;
  logic          gate_run_reg;
  logic          supply_n_d_reg;
  logic          gate_due;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_n_d_reg <= 1'b1;
    end else begin
      supply_n_d_reg <= supply_on_n_o;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_run_reg <= 1'b0;
      gate_cnt_reg <= '0;
    end else if (supply_on_n_o) begin
      gate_run_reg <= 1'b0;
      gate_cnt_reg <= '0;
    end else if (supply_n_d_reg) begin
      gate_run_reg <= 1'b1;
      gate_cnt_reg <= '0;
    end else if (gate_run_reg && ms_tick) begin
      if (gate_cnt_reg == TW'(GATE_TICKS - 1)) begin
        gate_run_reg <= 1'b0;
      end
      gate_cnt_reg <= gate_cnt_reg + TW'(1);
    end
  end

  // The counter stops at GATE_TICKS and holds there while the supply stays on,
  // so a short sleep that never drops the supply releases the gate again as
  // soon as the sleep input returns high.
  assign gate_due = (gate_cnt_reg == TW'(GATE_TICKS));

  // ----------------------------------------------------------------------------
  // Standby-rail gate output
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standby_rail_gate_n_o <= 1'b0;
    end else if (!sleep_n_s || supply_on_n_o) begin
      standby_rail_gate_n_o <= 1'b0;
    end else if (gate_due) begin
      standby_rail_gate_n_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------------
  // Read data stands for one cycle after the strobe and is zero otherwise,
  // so a bus that merges several slaves never sees a stale value.
  logic [`PLRC_DATA_W-1:0] rd_val;

  always_comb begin
    rd_val = '0;
    unique case (addr_i)
      `PLRC_ADDR_POLICY: begin
        rd_val[`PLRC_POLICY_MSB:`PLRC_POLICY_LSB] = policy_reg;
      end
      `PLRC_ADDR_LAST: begin
        rd_val[`PLRC_LAST_BIT] = last_off_reg;
      end
      `PLRC_ADDR_STATUS: begin
        rd_val[`PLRC_ST_SUPPLY_BIT]                      = supply_on_n_o;
        rd_val[`PLRC_ST_GATE_BIT]                        = standby_rail_gate_n_o;
        rd_val[`PLRC_ST_STATE_MSB:`PLRC_ST_STATE_LSB]    = state_reg;
        rd_val[`PLRC_ST_SLEEP_BIT]                       = sleep_n_s;
        rd_val[`PLRC_ST_RAIL_BIT]                        = rail_low_s;
        rd_val[`PLRC_ST_AC_BIT]                          = ac_good_s;
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rd_val;
    end else begin
      rdata_o <= '0;
    end
  end

endmodule

// File: sim/plrc_chk.sv
`timescale 1ns/1ps
`include "plrc_regs.svh"
module plrc_chk #(
  parameter int CYC_PER_MS = 40000
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       sleep_state_n_i,
  input wire logic       ac_good_i,
  input wire logic       supply_on_n_o,
  input wire logic       standby_rail_gate_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] pol_q;
  int         slp_cnt;
  int         on_cnt;
  // Policy shadow and the time spent asleep and powered.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pol_q   <= 2'h0;
      slp_cnt <= 0;
      on_cnt  <= 0;
    end else begin
      if (wr_i && addr_i == `PLRC_ADDR_POLICY) pol_q <= wdata_i[6:5];
      slp_cnt <= sleep_state_n_i ? 0 : slp_cnt + 1;
      on_cnt  <= supply_on_n_o ? 0 : on_cnt + 1;
    end
  end
  sequence s_ac_back(logic [1:0] p);
    pol_q == p && $rose(ac_good_i);
  endsequence
  sequence s_sleep_go;
    $fell(sleep_state_n_i) && ac_good_i;
  endsequence
  sequence s_wake;
    $rose(sleep_state_n_i) && ac_good_i;
  endsequence
  a_stay_off: assert property (s_ac_back(2'h0) |-> supply_on_n_o [*8])
    else $error("supply switched on under off policy");
  a_turn_on: assert property (s_ac_back(2'h1) |-> ##[1:5] !supply_on_n_o)
    else $error("supply not switched on under on policy");
  a_gate_prompt: assert property (s_sleep_go |-> ##[0:3] !standby_rail_gate_n_o)
    else $error("gate late after sleep");
  a_wake_prompt: assert property (s_wake |-> ##[0:4] !supply_on_n_o)
    else $error("supply late after wake");
  a_off_early: assert property ($rose(supply_on_n_o) && ac_good_i |->
    slp_cnt >= 28 * CYC_PER_MS)
    else $error("supply dropped too early");
  a_off_late: assert property (slp_cnt == 39 * CYC_PER_MS + 1 |-> supply_on_n_o)
    else $error("supply dropped too late");
  a_gate_early: assert property ($rose(standby_rail_gate_n_o) |->
    on_cnt >= 90 * CYC_PER_MS)
    else $error("gate released too early");
  a_gate_late: assert property (on_cnt == 142 * CYC_PER_MS + 1 && sleep_state_n_i |->
    standby_rail_gate_n_o)
    else $error("gate released too late");
  a_policy_field: assert property (rd_i && addr_i == `PLRC_ADDR_POLICY |=>
    rdata_o == {1'b0, pol_q, 5'h00})
    else $error("policy read mismatch");
  a_flag_field: assert property (rd_i && addr_i == `PLRC_ADDR_LAST |=>
    rdata_o[7:5] == 3'h0 && rdata_o[3:0] == 4'h0)
    else $error("flag register stray bits");
endmodule
bind plrc_top plrc_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .sleep_state_n_i(sleep_state_n_i), .ac_good_i(ac_good_i),
  .supply_on_n_o(supply_on_n_o), .standby_rail_gate_n_o(standby_rail_gate_n_o));

// File: sim/plrc_platform.sv
`timescale 1ns/1ps
module plrc_platform (
  input  wire logic clk_i,
  input  wire logic ac_req_i,
  input  wire logic supply_on_n_i,
  output logic      ac_good_o,
  output logic      main_rail_low_o
);
  logic [2:0] ac_q   = 3'h0;
  logic       rail_q = 1'b1;
  // The main rail collapses before standby sense drops, and is down while the supply is off.
  always_ff @(posedge clk_i) begin
    ac_q   <= {ac_q[1:0], ac_req_i};
    rail_q <= !ac_req_i || supply_on_n_i;
  end
  assign ac_good_o       = ac_q[2];
  assign main_rail_low_o = rail_q;
endmodule

// File: sim/test_plrc_top.sv
`timescale 1ns/1ps
`include "plrc_regs.svh"
module test_plrc_top;
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] addr_i  = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [7:0] a;
  logic       wr_i    = 1'b0;
  logic       rd_i    = 1'b0;
  logic       sleep_n = 1'b1;
  logic       ac_req  = 1'b0;
  logic       rail_low, ac_good, supply_n, gate_n;
  logic [1:0] pol_m   = 2'h0;
  logic       flag_m  = 1'b1;
  int         seed = 31769, n_mismatch = 0, samples_checked = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  plrc_top #(.CYC_PER_MS(10)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sleep_state_n_i(sleep_n), .main_rail_low_i(rail_low),
    .ac_good_i(ac_good), .supply_on_n_o(supply_n), .standby_rail_gate_n_o(gate_n));
  plrc_platform plat_u (.clk_i(clk_i), .ac_req_i(ac_req), .supply_on_n_i(supply_n),
    .ac_good_o(ac_good), .main_rail_low_o(rail_low));
  function automatic logic [7:0] exp_rd(logic [7:0] ad);
    if (ad == `PLRC_ADDR_POLICY) return {1'b0, pol_m, 5'h00};
    if (ad == `PLRC_ADDR_LAST) return {3'h0, flag_m, 4'h0};
    return 8'h00;
  endfunction
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk1(string nm, logic e, logic s);
    chk8(nm, {7'h00, e}, {7'h00, s});
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= ad;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (ad == `PLRC_ADDR_POLICY) pol_m = d[6:5];
    if (ad == `PLRC_ADDR_LAST) flag_m = d[4];
  endtask
  task automatic rd(logic [7:0] ad);
    @(posedge clk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk8("rdata", exp_rd(ad), rdata_o);
  endtask
  task automatic ac(logic on, logic exp_n);
    @(posedge clk_i);
    ac_req <= on;
    wt(20);
    chk1("supply", exp_n, supply_n);
  endtask
  task automatic slp(logic v);
    @(posedge clk_i);
    sleep_n <= v;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`PLRC_ADDR_POLICY);
    rd(`PLRC_ADDR_LAST);
    for (int i = 0; i < 12; i++) begin
      a = (i % 3 == 0) ? `PLRC_ADDR_POLICY : (i % 3 == 1) ? `PLRC_ADDR_LAST : 8'h50;
      if (i % 3 == 2) a[3:0] = 4'($random(seed));
      wr(a, 8'($random(seed)));
      rd(a);
    end
    wr(`PLRC_ADDR_POLICY, 8'h00);
    wr(`PLRC_ADDR_LAST, 8'h00);
    ac(1'b1, 1'b1);
    ac(1'b0, 1'b1);
    wr(`PLRC_ADDR_POLICY, 8'h20);
    ac(1'b1, 1'b0);
    wt(930);
    chk1("gate", 1'b1, gate_n);
    slp(1'b0);
    wt(4);
    chk1("gate", 1'b0, gate_n);
    wt(100);
    slp(1'b1);
    wt(4);
    chk1("supply", 1'b0, supply_n);
    chk1("gate", 1'b1, gate_n);
    wr(`PLRC_ADDR_LAST, 8'h10);
    ac(1'b0, 1'b1);
    flag_m = 1'b0;
    rd(`PLRC_ADDR_LAST);
    wr(`PLRC_ADDR_POLICY, 8'h40);
    ac(1'b1, 1'b0);
    slp(1'b0);
    wt(270);
    chk1("supply", 1'b0, supply_n);
    wt(115);
    chk1("supply", 1'b1, supply_n);
    flag_m = 1'b1;
    rd(`PLRC_ADDR_LAST);
    ac(1'b0, 1'b1);
    ac(1'b1, 1'b1);
    slp(1'b1);
    wt(5);
    chk1("supply", 1'b0, supply_n);
    wr(`PLRC_ADDR_POLICY, 8'h60);
    wr(`PLRC_ADDR_LAST, 8'h10);
    ac(1'b0, 1'b1);
    rd(`PLRC_ADDR_LAST);
    ac(1'b1, 1'b1);
    ac(1'b0, 1'b1);
    wr(`PLRC_ADDR_LAST, 8'h00);
    ac(1'b1, 1'b0);
    wt(1450);
    chk1("gate", 1'b1, gate_n);
    summarize();
  end
endmodule
